// [design/eac_nvm_if.sv]
`timescale 1ns/100ps
`default_nettype none

// Link between the register front end and the programming engine
interface eac_nvm_if;
   logic start;
   logic [1:0] mode;
   logic [8:0] addr;
   logic [7:0] data;
   logic rc_tick;
   logic busy;
   logic [1:0] cur_mode;
   logic [8:0] rd_addr;
   logic [7:0] rd_data;

   modport ctl (output start, output mode, output addr, output data, output rc_tick,
                output rd_addr, input busy, input cur_mode, input rd_data);
   modport eng (input start, input mode, input addr, input data, input rc_tick,
                input rd_addr, output busy, output cur_mode, output rd_data);
endinterface // eac_nvm_if

`default_nettype wire

// [design/eac_pkg.sv]
package eac_pkg;

   // ***************************************************
   // Storage geometry
   // ***************************************************
   localparam int unsigned MEM_BYTES = 512;
   localparam int unsigned AW = 9;
   localparam logic [7:0] ERASED_BYTE = 8'hff;

   // ***************************************************
   // Register offsets (I/O form) and data-space shift
   // ***************************************************
   localparam logic [6:0] OFS_CTRL = 7'h1c;
   localparam logic [6:0] OFS_DATA = 7'h1d;
   localparam logic [6:0] OFS_ADDR_LO = 7'h1e;
   localparam logic [6:0] OFS_ADDR_HI = 7'h1f;
   localparam logic [6:0] DS_OFFSET = 7'h20;
   localparam logic [6:0] BIT_ACCESS_LIMIT = 7'h20;

   // ***************************************************
   // Control register field positions
   // ***************************************************
   localparam int unsigned CTRL_READ_BIT = 0;
   localparam int unsigned CTRL_PROG_BIT = 1;
   localparam int unsigned CTRL_ARM_BIT = 2;
   localparam int unsigned CTRL_IRQEN_BIT = 3;
   localparam int unsigned CTRL_MODE_LSB = 4;

   // ***************************************************
   // Reset values
   // ***************************************************
   localparam logic [1:0] MODE_RST = 2'h0;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [8:0] ADDR_RST = 9'h000;

   // ***************************************************
   // Cycle counts on clk_sys
   // ***************************************************
   localparam logic [2:0] READ_STALL_CYC = 3'h4;
   localparam logic [2:0] PROG_STALL_CYC = 3'h2;
   localparam logic [2:0] ARM_WINDOW_CYC = 3'h4;

   // ***************************************************
   // Programming times, counted in RC oscillator periods
   // ***************************************************
   localparam int unsigned RC_PERIOD_NS = 125;
   localparam int unsigned T_ATOMIC_NS = 3400000;
   localparam int unsigned T_SPLIT_NS = 1800000;
   localparam int unsigned TICK_W = 16;
   localparam int unsigned ATOMIC_TICKS = (T_ATOMIC_NS + RC_PERIOD_NS - 1) / RC_PERIOD_NS;
   localparam int unsigned SPLIT_TICKS = (T_SPLIT_NS + RC_PERIOD_NS - 1) / RC_PERIOD_NS;

   // ***************************************************
   // Types
   // ***************************************************
   typedef enum logic [1:0] {
      EAC_MODE_ATOMIC = 2'b00,
      EAC_MODE_ERASE = 2'b01,
      EAC_MODE_WRITE = 2'b10,
      EAC_MODE_RSVD = 2'b11
   } eac_mode_t;

   typedef enum logic [1:0] {
      EAC_ENG_IDLE = 2'b00,
      EAC_ENG_RUN = 2'b01
   } eac_eng_state_t;

endpackage

// [design/eac_prog_engine.sv]
`timescale 1ns/100ps
`default_nettype none

// Self-timed programming engine and the byte array it owns
module eac_prog_engine #(
   parameter logic [15:0] ATOMIC_TICKS = 16'(eac_pkg::ATOMIC_TICKS),
   parameter logic [15:0] SPLIT_TICKS = 16'(eac_pkg::SPLIT_TICKS)
) (
   input wire logic clk_sys,
   input wire logic por_n,
   input wire logic ce,
   eac_nvm_if.eng nvm
);
   logic [7:0] mem_q [eac_pkg::MEM_BYTES];
   eac_pkg::eac_eng_state_t state_q;
   logic [15:0] cnt_q;
   logic [1:0] mode_q;
   logic [8:0] addr_q;
   logic [7:0] data_q;
   logic finish;
   logic [7:0] new_byte;
   logic [15:0] load_ticks;

   // Operation end and byte result; write-only can only clear bits
   assign finish = (state_q == eac_pkg::EAC_ENG_RUN) && nvm.rc_tick && (cnt_q == 16'h0001);
   assign new_byte = (mode_q == eac_pkg::EAC_MODE_ERASE) ? eac_pkg::ERASED_BYTE :
                     (mode_q == eac_pkg::EAC_MODE_WRITE) ? (mem_q[addr_q] & data_q) : data_q;
   // [RULE_19] mode-dependent duration
   assign load_ticks = (nvm.mode == eac_pkg::EAC_MODE_ATOMIC) ? ATOMIC_TICKS : SPLIT_TICKS;
   assign nvm.busy = (state_q == eac_pkg::EAC_ENG_RUN);
   assign nvm.cur_mode = mode_q;
   assign nvm.rd_data = mem_q[nvm.rd_addr];

   // Sequencer; only power-on reset touches it so system reset lets it finish
   // [RULE_11] survives system reset
   always_ff @(posedge clk_sys or negedge por_n) begin
      if (!por_n) begin
         state_q <= eac_pkg::EAC_ENG_IDLE;
         cnt_q <= 16'h0000;
         mode_q <= eac_pkg::MODE_RST;
         addr_q <= eac_pkg::ADDR_RST;
         data_q <= eac_pkg::DATA_RST;
      end else if (ce) begin
         case (state_q)
            eac_pkg::EAC_ENG_IDLE: begin
               if (nvm.start) begin
                  state_q <= eac_pkg::EAC_ENG_RUN;
                  cnt_q <= load_ticks;
                  mode_q <= nvm.mode;
                  addr_q <= nvm.addr;
                  data_q <= nvm.data;
               end
            end
            // [RULE_12] RC-timed duration
            eac_pkg::EAC_ENG_RUN: begin
               if (finish) begin
                  state_q <= eac_pkg::EAC_ENG_IDLE;
               end
               if (nvm.rc_tick) begin
                  cnt_q <= cnt_q - 16'h0001;
               end
            end
            default: state_q <= eac_pkg::EAC_ENG_IDLE;
         endcase
      end
   end

   // Byte array update at the end of an operation
   always_ff @(posedge clk_sys) begin
      if (ce && finish) begin
         mem_q[addr_q] <= new_byte;
      end
   end
endmodule // eac_prog_engine

`default_nettype wire

// [design/eac_rc_tick.sv]
`timescale 1ns/100ps
`default_nettype none

// Turns the RC oscillator pin into a one-cycle tick per rising edge
module eac_rc_tick (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic ce,
   input wire logic rc_osc_in,
   output logic rc_tick_q
);
   logic sync1_q;
   logic sync2_q;
   logic prev_q;

   // Two-stage synchroniser, then edge detect on the second stage
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         prev_q <= 1'b0;
         rc_tick_q <= 1'b0;
      end else if (ce) begin
         sync1_q <= rc_osc_in;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
         rc_tick_q <= sync2_q & ~prev_q;
      end
   end
endmodule // eac_rc_tick

`default_nettype wire

// [design/eac_top.sv]
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// [RULE_01] Separate 512-byte nonvolatile space, read and written one byte at a time.
// [RULE_02] Address, data and control registers sit in the core's I/O space.
// [RULE_03] A triggered read stalls the core for four clock cycles.
// [RULE_04] A triggered programming access stalls the core for two clock cycles.
// [RULE_05] Mode 00 plus armed strobe starts combined erase and write.
// [RULE_06] Mode 01 plus armed strobe starts an erase of the addressed byte.
// [RULE_07] Mode 10 plus armed strobe writes the data register into the byte.
// [RULE_08] Programming strobe reads set until the operation ends, then hardware clears it.
// [RULE_09] While programming, reads and new programming requests are refused.
// [RULE_10] Software erases a byte before write-only; otherwise its value is lost.
// [RULE_11] A system reset does not abort a running programming operation.
// [RULE_12] Programming duration is timed by the calibrated RC oscillator.
// [RULE_13] Software polls the programming strobe until clear before any access.
// [RULE_14] Software sets mode, address, data, then arm, then strobe separately.
// [RULE_15] Read strobe loads the addressed byte into the data register at once.
// [RULE_16] Addresses below 0x20 accept single-bit set and clear operations.
// [RULE_17] Data-space accesses see the registers 0x20 above their I/O addresses.
// [RULE_18] Arm bit self-clears four cycles after set; unarmed strobe does nothing.
// [RULE_19] Combined operation takes 3.4 ms, erase or write alone 1.8 ms.
// [RULE_20] Mode field writes are ignored while programming is running.
// [RULE_21] Ready interrupt holds while enabled, globally enabled and not busy.
// [RULE_22] Reserved mode 11 starts nothing and leaves stored data unchanged.
module eac_top #(
   parameter logic [15:0] ATOMIC_TICKS = 16'(eac_pkg::ATOMIC_TICKS),
   parameter logic [15:0] SPLIT_TICKS = 16'(eac_pkg::SPLIT_TICKS)
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic por_n,
   input wire logic ce,
   input wire logic [6:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic bit_wr,
   input wire logic [2:0] bit_idx,
   input wire logic global_ie,
   input wire logic rc_osc_in,
   output logic [7:0] rdata_q,
   output logic cpu_stall_q,
   output logic ready_irq_q
);

   // ***************************************************
   // Functions
   // ***************************************************

   // Register hit in either the I/O or the data-space form
   function automatic logic reg_hit(input logic [6:0] a, input logic [6:0] ofs);
      reg_hit = (a == ofs) || (a == (ofs + eac_pkg::DS_OFFSET));
   endfunction

   // Replace one bit of a byte, leaving the rest untouched
   function automatic logic [7:0] merge_bit(input logic [7:0] cur, input logic [2:0] idx,
                                            input logic val);
      logic [7:0] mask;
      mask = 8'h01 << idx;
      merge_bit = val ? (cur | mask) : (cur & ~mask);
   endfunction

   // ***************************************************
   // Declarations
   // ***************************************************
   eac_nvm_if nvm ();

   logic [1:0] mode_q;
   logic irq_en_q;
   logic [2:0] arm_cnt_q;
   logic [2:0] arm_cnt_d;
   logic [8:0] addr_q;
   logic [7:0] data_q;
   logic [7:0] data_d;
   logic [2:0] stall_cnt_q;
   logic [2:0] stall_cnt_d;
   logic rc_tick;

   logic hit_ctrl;
   logic hit_data;
   logic hit_lo;
   logic hit_hi;
   logic bit_ok;
   logic wr_any;
   logic busy;
   logic arm_on;
   logic [7:0] ctrl_view;
   logic [7:0] rb_val;
   logic [7:0] wval;
   logic ctrl_wr;
   logic arm_set;
   logic prog_req;
   logic read_req;

   // ***************************************************
   // RC oscillator tick and programming engine
   // ***************************************************
   eac_rc_tick u_rc_tick (
      .clk_sys (clk_sys),
      .arst_n (arst_n),
      .ce (ce),
      .rc_osc_in (rc_osc_in),
      .rc_tick_q (rc_tick)
   );

   eac_prog_engine #(
      .ATOMIC_TICKS (ATOMIC_TICKS),
      .SPLIT_TICKS (SPLIT_TICKS)
   ) u_engine (
      .clk_sys (clk_sys),
      .por_n (por_n),
      .ce (ce),
      .nvm (nvm.eng)
   );

   // Engine request fields come straight from the registers
   assign nvm.rc_tick = rc_tick;
   assign nvm.mode = mode_q;
   assign nvm.addr = addr_q;
   assign nvm.data = data_q;
   assign nvm.rd_addr = addr_q;
   assign nvm.start = prog_req;
   assign busy = nvm.busy;

   // ***************************************************
   // Address decode
   // ***************************************************

   // Same registers at I/O offset and shifted data-space offset
   // [RULE_17] data-space mirror
   assign hit_ctrl = reg_hit(addr, eac_pkg::OFS_CTRL);
   assign hit_data = reg_hit(addr, eac_pkg::OFS_DATA);
   assign hit_lo = reg_hit(addr, eac_pkg::OFS_ADDR_LO);
   assign hit_hi = reg_hit(addr, eac_pkg::OFS_ADDR_HI);

   // Bit operations only through the low I/O form
   // [RULE_16] single-bit access
   assign bit_ok = bit_wr && (addr < eac_pkg::BIT_ACCESS_LIMIT);
   assign wr_any = wr | bit_ok;

   // ***************************************************
   // Read-back view
   // ***************************************************

   // Control byte; mode shows the running operation while busy
   // [RULE_08] strobe reads busy
   assign arm_on = (arm_cnt_q != 3'h0);
   always_comb begin
      ctrl_view = 8'h00;
      ctrl_view[eac_pkg::CTRL_MODE_LSB +: 2] = busy ? nvm.cur_mode : mode_q;
      ctrl_view[eac_pkg::CTRL_IRQEN_BIT] = irq_en_q;
      ctrl_view[eac_pkg::CTRL_ARM_BIT] = arm_on;
      ctrl_view[eac_pkg::CTRL_PROG_BIT] = busy;
   end

   // Read mux; unmapped addresses read zero
   // [RULE_02] I/O register map
   assign rb_val = hit_ctrl ? ctrl_view :
                   hit_data ? data_q :
                   hit_lo ? addr_q[7:0] :
                   hit_hi ? {7'h00, addr_q[8]} : 8'h00;

   // Effective write byte, whole or single bit
   assign wval = bit_ok ? merge_bit(rb_val, bit_idx, wdata[0]) : wdata;

   // ***************************************************
   // Control register actions
   // ***************************************************
   assign ctrl_wr = wr_any && hit_ctrl;

   // Arm starts its window only on a 0 to 1 write
   assign arm_set = ctrl_wr && wval[eac_pkg::CTRL_ARM_BIT] && !arm_on;

   // Start needs arm, an idle engine and a defined mode
   // [RULE_05] atomic start
   // [RULE_06] erase start
   // [RULE_07] write start
   // [RULE_22] reserved mode ignored
   assign prog_req = ctrl_wr && wval[eac_pkg::CTRL_PROG_BIT] && arm_on && !busy &&
                     (mode_q != eac_pkg::EAC_MODE_RSVD);

   // Read trigger refused while programming
   // [RULE_09] busy lockout
   assign read_req = ctrl_wr && wval[eac_pkg::CTRL_READ_BIT] && !busy;

   // Arm window counter
   // [RULE_18] four-cycle arm
   assign arm_cnt_d = arm_set ? eac_pkg::ARM_WINDOW_CYC :
                      arm_on ? (arm_cnt_q - 3'h1) : 3'h0;

   // Core stall length per access kind
   // [RULE_03] read stall four
   // [RULE_04] program stall two
   assign stall_cnt_d = read_req ? eac_pkg::READ_STALL_CYC :
                        prog_req ? eac_pkg::PROG_STALL_CYC :
                        (stall_cnt_q != 3'h0) ? (stall_cnt_q - 3'h1) : 3'h0;

   // Data register: read result wins the cycle of a read trigger
   // [RULE_15] read into data
   // [RULE_01] byte read path
   assign data_d = read_req ? nvm.rd_data :
                   (wr_any && hit_data) ? wval : data_q;

   // ***************************************************
   // Control and timing registers
   // ***************************************************

   // Mode field held while the engine runs
   // [RULE_20] mode write ignored
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         mode_q <= eac_pkg::MODE_RST;
         irq_en_q <= 1'b0;
      end else if (ce && ctrl_wr) begin
         if (!busy) begin
            mode_q <= wval[eac_pkg::CTRL_MODE_LSB +: 2];
         end
         irq_en_q <= wval[eac_pkg::CTRL_IRQEN_BIT];
      end
   end

   // Arm and stall counters
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         arm_cnt_q <= 3'h0;
         stall_cnt_q <= 3'h0;
      end else if (ce) begin
         arm_cnt_q <= arm_cnt_d;
         stall_cnt_q <= stall_cnt_d;
      end
   end

   // ***************************************************
   // Address and data registers
   // ***************************************************

   // Address frozen during programming
   // [RULE_09] address locked
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         addr_q <= eac_pkg::ADDR_RST;
      end else if (ce && wr_any && !busy) begin
         if (hit_lo) begin
            addr_q[7:0] <= wval;
         end
         if (hit_hi) begin
            addr_q[8] <= wval[0];
         end
      end
   end

   // Data register
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         data_q <= eac_pkg::DATA_RST;
      end else if (ce) begin
         data_q <= data_d;
      end
   end

   // ***************************************************
   // Outputs
   // ***************************************************

   // Read data one cycle after the strobe, stall and ready level
   // [RULE_21] ready interrupt level
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rdata_q <= 8'h00;
         cpu_stall_q <= 1'b0;
         ready_irq_q <= 1'b0;
      end else if (ce) begin
         rdata_q <= rd ? rb_val : 8'h00;
         cpu_stall_q <= (stall_cnt_d != 3'h0);
         ready_irq_q <= irq_en_q && global_ie && !busy;
      end
   end

endmodule // eac_top

`default_nettype wire

// [sim/eac_rc_osc.sv]
`timescale 1ns/100ps
`default_nettype none

// ***************************************************
// Calibrated RC oscillator source
// ***************************************************
module eac_rc_osc #(
   parameter realtime HALF_NS = 40.0
) (
   output logic rc_osc
);
   initial begin
      rc_osc = 1'b0;
      #7.3;
      forever #(HALF_NS) rc_osc = ~rc_osc;
   end
endmodule // eac_rc_osc

`default_nettype wire

// [sim/eac_top_chk.sv]
`timescale 1ns/100ps
`default_nettype none

// ***************************************************
// Port checker for the access controller
// ***************************************************
module eac_top_chk #(
   parameter logic [15:0] ATOMIC_TICKS = 16'h0004,
   parameter logic [15:0] SPLIT_TICKS = 16'h0002
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic por_n,
   input wire logic ce,
   input wire logic [6:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic bit_wr,
   input wire logic [2:0] bit_idx,
   input wire logic global_ie,
   input wire logic rc_osc_in,
   input wire logic [7:0] rdata_q,
   input wire logic cpu_stall_q,
   input wire logic ready_irq_q
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   // Address decode, I/O and data-space forms
   wire logic is_ctrl = (addr == eac_pkg::OFS_CTRL) || (addr == 7'h3c);
   wire logic is_hi = (addr == eac_pkg::OFS_ADDR_HI) || (addr == 7'h3f);
   wire logic mapped = (addr[4:2] == 3'h7) && (addr[6] == 1'b0);

   a_read_stall_four: assert property (
      wr && is_ctrl && wdata[1:0] == 2'b01 && !cpu_stall_q
      |=> (cpu_stall_q [*4] ##1 !cpu_stall_q) or !cpu_stall_q)
      else $error("read stall is not four cycles");
   a_prog_stall_two: assert property (
      bit_wr && is_ctrl && bit_idx == 3'h1 && wdata[0] && !cpu_stall_q
      |=> (cpu_stall_q [*2] ##1 !cpu_stall_q) or !cpu_stall_q)
      else $error("programming stall is not two cycles");
   a_stall_has_cause: assert property (
      $rose(cpu_stall_q) |-> $past((wr || bit_wr) && is_ctrl))
      else $error("stall without a control access");
   a_rdata_idle_zero: assert property (
      !rd |=> rdata_q == 8'h00)
      else $error("read data outside a read cycle");
   a_unmapped_reads_zero: assert property (
      rd && !mapped |=> rdata_q == 8'h00)
      else $error("unmapped address returned data");
   a_ctrl_fixed_bits: assert property (
      rd && is_ctrl |=> rdata_q[7:6] == 2'b00 && !rdata_q[0])
      else $error("control byte fixed bits wrong");
   a_addr_hi_zero: assert property (
      rd && is_hi |=> rdata_q[7:1] == 7'h00)
      else $error("address high byte upper bits set");
   a_irq_needs_gie: assert property (
      !global_ie |=> !ready_irq_q)
      else $error("ready interrupt without global enable");
   a_mirror_same_data: assert property (
      (rd && addr == eac_pkg::OFS_DATA) ##2 (rd && addr == 7'h3d)
      |=> rdata_q == $past(rdata_q, 2))
      else $error("data-space mirror differs");
   a_reset_outputs_low: assert property (
      $rose(arst_n) |-> rdata_q == 8'h00 && !cpu_stall_q && !ready_irq_q)
      else $error("outputs not cleared by reset");
   a_ce_freeze_outputs: assert property (
      !ce |=> $stable(rdata_q) && $stable(cpu_stall_q) && $stable(ready_irq_q))
      else $error("outputs moved while clock enable low");
endmodule // eac_top_chk

bind eac_top eac_top_chk #(.ATOMIC_TICKS(ATOMIC_TICKS), .SPLIT_TICKS(SPLIT_TICKS)) chk_u (
   .clk_sys(clk_sys), .arst_n(arst_n), .por_n(por_n), .ce(ce), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .bit_wr(bit_wr), .bit_idx(bit_idx),
   .global_ie(global_ie), .rc_osc_in(rc_osc_in), .rdata_q(rdata_q),
   .cpu_stall_q(cpu_stall_q), .ready_irq_q(ready_irq_q));

`default_nettype wire

// [sim/test_eeprom_access_controller.sv]
`timescale 1ns/100ps
`default_nettype none

module test_eeprom_access_controller;
   localparam logic [6:0] CT = eac_pkg::OFS_CTRL;
   localparam logic [6:0] DT = eac_pkg::OFS_DATA;
   localparam logic [6:0] AL = eac_pkg::OFS_ADDR_LO;
   localparam logic [6:0] AH = eac_pkg::OFS_ADDR_HI;
   logic clk_sys = 1'b0;
   logic arst_n, por_n, ce, wr, rd, bit_wr, global_ie, ie_sel;
   logic [6:0] addr;
   logic [7:0] wdata, v, d, d2;
   logic [2:0] bit_idx;
   logic [8:0] a;
   wire logic rc;
   wire logic [7:0] rdata_q;
   wire logic cpu_stall_q, ready_irq_q;
   int mismatches = 0;
   int samples_checked = 0;
   int stall_cnt = 0;

   // ***************************************************
   // Clock, design and oscillator
   // ***************************************************
   always #2.5 clk_sys = ~clk_sys;

   eac_top #(.ATOMIC_TICKS(16'h0004), .SPLIT_TICKS(16'h0002)) dut_u (
      .clk_sys(clk_sys), .arst_n(arst_n), .por_n(por_n), .ce(ce), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .bit_wr(bit_wr), .bit_idx(bit_idx),
      .global_ie(global_ie), .rc_osc_in(rc), .rdata_q(rdata_q),
      .cpu_stall_q(cpu_stall_q), .ready_irq_q(ready_irq_q));
   eac_rc_osc rc_u (.rc_osc(rc));

   // Counts stalled cycles
   always @(negedge clk_sys) if (cpu_stall_q === 1'b1) stall_cnt++;

   // ***************************************************
   // Bus tasks and comparisons
   // ***************************************************
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic drv(input logic w, input logic r, input logic b, input logic [6:0] ad,
                      input logic [7:0] dt, input logic [2:0] bi);
      wr <= w; rd <= r; bit_wr <= b; addr <= ad; wdata <= dt; bit_idx <= bi;
      @(posedge clk_sys);
      wr <= 1'b0; rd <= 1'b0; bit_wr <= 1'b0;
      @(negedge clk_sys);
      v = rdata_q;
      @(posedge clk_sys);
   endtask
   task automatic wr_reg(input logic [6:0] ad, input logic [7:0] dt);
      drv(1'b1, 1'b0, 1'b0, ad, dt, 3'h0);
   endtask
   task automatic rd_reg(input logic [6:0] ad);
      drv(1'b0, 1'b1, 1'b0, ad, 8'h00, 3'h0);
   endtask
   task automatic bset(input logic [6:0] ad, input logic [2:0] bi, input logic val);
      drv(1'b0, 1'b0, 1'b1, ad, {7'h00, val}, bi);
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("Error t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wait_done();
      repeat (100) begin
         rd_reg(CT);
         if (v[1] === 1'b0) break;
      end
      chk8(v & 8'h02, 8'h00);
   endtask
   task automatic prog(input logic [1:0] m, input logic [8:0] ad, input logic [7:0] dt,
                       input logic go, input logic w);
      wr_reg(CT, {2'b00, m, ie_sel, 3'b000});
      wr_reg(AL, ad[7:0]);
      wr_reg(AH, {7'h00, ad[8]});
      wr_reg(DT, dt);
      bset(CT, 3'h2, 1'b1);
      stall_cnt = 0;
      bset(CT, 3'h1, 1'b1);
      cyc(2);
      rd_reg(CT);
      chk8({7'h00, v[1]}, {7'h00, go});
      if (go) chk8(8'(stall_cnt), 8'h02);
      if (w) wait_done();
   endtask
   task automatic rdb(input logic [8:0] ad);
      wr_reg(AL, ad[7:0]);
      wr_reg(AH, {7'h00, ad[8]});
      stall_cnt = 0;
      wr_reg(CT, {4'h0, ie_sel, 3'b001});
      cyc(4);
      chk8(8'(stall_cnt), 8'h04);
      rd_reg(DT);
   endtask
   // Expected byte after a programming request, from the mode rules
   function automatic logic [7:0] exp_byte(input logic [1:0] m, input logic [7:0] old,
                                          input logic [7:0] dt);
      case (m)
         2'b00: exp_byte = dt;
         2'b01: exp_byte = eac_pkg::ERASED_BYTE;
         2'b10: exp_byte = old & dt;
         default: exp_byte = old;
      endcase
   endfunction
   task automatic conclude();
      if (mismatches == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Watchdog against a hang
   initial begin
      cyc(60000);
      mismatches++;
      conclude();
   end

   // ***************************************************
   // Main sequence
   // ***************************************************
   initial begin
      arst_n = 1'b0; por_n = 1'b0; ce = 1'b1; wr = 1'b0; rd = 1'b0; bit_wr = 1'b0;
      addr = 7'h00; wdata = 8'h00; bit_idx = 3'h0; global_ie = 1'b0; ie_sel = 1'b0;
      void'($urandom(62));
      cyc(10);
      arst_n <= 1'b1;
      por_n <= 1'b1;
      @(posedge clk_sys);
      // Reset values and an unmapped address
      for (int i = 0; i < 5; i++) begin
         rd_reg(i == 4 ? 7'h05 : CT + 7'(i));
         chk8(v, 8'h00);
      end
      // Data-space mirror and single-bit access
      wr_reg(DT | eac_pkg::DS_OFFSET, 8'h5a);
      rd_reg(DT); chk8(v, 8'h5a);
      rd_reg(DT | eac_pkg::DS_OFFSET); chk8(v, 8'h5a);
      bset(DT | eac_pkg::DS_OFFSET, 3'h1, 1'b0);
      bset(DT, 3'h3, 1'b0);
      rd_reg(DT); chk8(v, 8'h52);
      // Clock enable low freezes the data register
      ce <= 1'b0;
      wr_reg(DT, 8'hff);
      ce <= 1'b1;
      rd_reg(DT); chk8(v, 8'h52);
      // Every mode on corner and random addresses
      for (int i = 0; i < 4; i++) begin
         a = (i == 0) ? 9'h000 : (i == 1) ? 9'h1ff : 9'($urandom);
         d = 8'($urandom);
         d2 = 8'($urandom);
         prog(2'b00, a, d, 1'b1, 1'b1); rdb(a);
         chk8(v, exp_byte(2'b00, 8'h00, d));
         prog(2'b01, a, 8'h00, 1'b1, 1'b1); rdb(a);
         chk8(v, exp_byte(2'b01, d, 8'h00));
         // write-only lands on the byte just erased
         prog(2'b10, a, d2, 1'b1, 1'b1); rdb(a);
         chk8(v, exp_byte(2'b10, eac_pkg::ERASED_BYTE, d2));
         prog(2'b11, a, d, 1'b0, 1'b0); rdb(a);
         chk8(v, exp_byte(2'b11, d2, d));
      end
      // Accesses refused while busy
      prog(2'b00, 9'h0a5, 8'h3c, 1'b1, 1'b0);
      wr_reg(AL, 8'h11);
      wr_reg(CT, 8'h11);
      rd_reg(CT); chk8(v & 8'h32, 8'h02);
      rd_reg(DT); chk8(v, 8'h3c);
      wait_done();
      rd_reg(AL); chk8(v, 8'ha5);
      rdb(9'h0a5); chk8(v, 8'h3c);
      // Unarmed strobe, arm visibility and expiry
      bset(CT, 3'h1, 1'b1); rd_reg(CT); chk8(v & 8'h02, 8'h00);
      bset(CT, 3'h2, 1'b1); rd_reg(CT); chk8(v & 8'h04, 8'h04);
      cyc(6);
      bset(CT, 3'h1, 1'b1); rd_reg(CT); chk8(v & 8'h06, 8'h00);
      // System reset in mid-programming
      prog(2'b00, 9'h123, 8'hc3, 1'b1, 1'b0);
      arst_n <= 1'b0;
      cyc(2);
      arst_n <= 1'b1;
      cyc(1);
      rd_reg(CT); chk8(v & 8'h02, 8'h02);
      wait_done();
      rdb(9'h123); chk8(v, 8'hc3);
      // Ready interrupt level
      ie_sel = 1'b1;
      global_ie <= 1'b1;
      wr_reg(CT, 8'h08);
      @(negedge clk_sys); chk8({7'h00, ready_irq_q}, 8'h01);
      prog(2'b00, 9'h044, 8'h77, 1'b1, 1'b0);
      @(negedge clk_sys); chk8({7'h00, ready_irq_q}, 8'h00);
      wait_done();
      @(negedge clk_sys); chk8({7'h00, ready_irq_q}, 8'h01);
      global_ie <= 1'b0;
      cyc(2);
      @(negedge clk_sys); chk8({7'h00, ready_irq_q}, 8'h00);
      conclude();
   end
endmodule // test_eeprom_access_controller

`default_nettype wire
